/* rtl/cswt_pkg.sv */
// Purpose: Shared constants, field layout and types of the cyclic sense
//          wake timer.
// Assumes: 125 MHz system clock; registers reached over 32-bit APB.
// Notes:   Timer periods and on-times are counted in 0.1 ms ticks.
package cswt_pkg;

    // Timing.
    localparam int unsigned CLK_MHZ  = 125;
    localparam int unsigned TICK_NS  = 100000;
    localparam int unsigned TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    localparam int unsigned FILT_NS  = 16000;
    localparam int unsigned FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CNT_W    = 15;
    localparam int unsigned FILT_W   = 11;

    // Sizes.
    localparam int unsigned N_TMR = 2;
    localparam int unsigned N_WK  = 3;
    localparam int unsigned N_HS  = 4;

    // Register byte offsets.
    localparam logic [7:0] ADDR_TMR1  = 8'h00;
    localparam logic [7:0] ADDR_TMR2  = 8'h04;
    localparam logic [7:0] ADDR_MAP1  = 8'h08;
    localparam logic [7:0] ADDR_MAP2  = 8'h0C;
    localparam logic [7:0] ADDR_WSRC  = 8'h10;
    localparam logic [7:0] ADDR_WST1  = 8'h14;
    localparam logic [7:0] ADDR_WST2  = 8'h18;
    localparam logic [7:0] ADDR_WLVL  = 8'h1C;
    localparam logic [7:0] ADDR_FAULT = 8'h20;

    // Field positions and codes.
    localparam int unsigned PER_LSB  = 0;
    localparam int unsigned ON_LSB   = 4;
    localparam int unsigned TWE_LSB  = 0;
    localparam int unsigned CSE_LSB  = 2;
    localparam int unsigned TSEL_LSB = 5;
    localparam int unsigned MAP_W    = 2;
    localparam logic [2:0] ON_OFF_HIGH = 3'h6;
    localparam logic [1:0] MAP_T1      = 2'h1;
    localparam logic [1:0] MAP_T2      = 2'h2;
    localparam logic [7:0] REG_RST     = 8'h00;

    // Device operating modes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_STOP   = 2'h1;
    localparam logic [1:0] MODE_SLEEP  = 2'h2;
    localparam logic [1:0] MODE_FSAFE  = 2'h3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } cswt_apb_req_t;

    // Period in ticks; zero marks an unusable code.
    function automatic logic [CNT_W-1:0] cswt_per_ticks(input logic [2:0] s);
        case (s)
            3'h0:    return 15'h0064;
            3'h1:    return 15'h00C8;
            3'h2:    return 15'h01F4;
            3'h3:    return 15'h03E8;
            3'h4:    return 15'h07D0;
            3'h5:    return 15'h2710;
            3'h6:    return 15'h4E20;
            default: return 15'h0000;
        endcase
    endfunction

    // On-time in ticks; zero means the timer is off.
    function automatic logic [CNT_W-1:0] cswt_on_ticks(input logic [2:0] s);
        case (s)
            3'h1:    return 15'h0001;
            3'h2:    return 15'h0003;
            3'h3:    return 15'h000A;
            3'h4:    return 15'h0064;
            3'h5:    return 15'h00C8;
            default: return 15'h0000;
        endcase
    endfunction

endpackage

/* rtl/cswt_top.sv */
// Purpose: Two cyclic timers driving high-side switches, cyclic sensing of
//          the wake inputs and cyclic wake interrupts, behind an APB slave.
// Assumes: dev_mode, sleep_req and hs_fault come from logic on clk_sys.
// Notes:   All timers share one 0.1 ms prescaler.
// How it works
// [RULE_01] A sensed wake input change wakes: interrupt, or supply rail restart.
// [RULE_02] A timer runs once a valid on-time is written, whatever else is set; the code also needs a valid period.
// [RULE_03] Software sets level, mapping, filter and pins, then period and on-time.
// [RULE_04] Off-low and off-high codes set the mapped switch level before sensing.
// [RULE_05] An on-time longer than the period sets the command fault flag.
// [RULE_06] The first sample is only a reference; later differences cause a wake.
// [RULE_07] A 16 us stable window after each on-time qualifies the sample.
// [RULE_08] A cyclic sense wake sets the flag of the input that changed.
// [RULE_09] In normal or stop, level status takes only sampled levels.
// [RULE_10] Fail-safe turns the switch off and falls back to static sensing.
// [RULE_11] A faulted switch turns off but its timer keeps running.
// [RULE_12] Software starts cyclic sense in normal mode before low-power modes.
// [RULE_13] A sleep request with any wake flag set restarts the device.
// [RULE_14] A timer enabled as wake source interrupts periodically in normal, stop.
// [RULE_15] Software disables timers, enables wake sources, then programs them.
// [RULE_16] Cyclic wake interrupts each on-time start except the first one.
// [RULE_17] Each switch may be mapped to either timer.
// [RULE_18] Seven periods: 10, 20, 50, 100, 200 ms, 1 s and 2 s.
// [RULE_19] On-times 0.1, 0.3, 1, 10, 20 ms, or off held high or low.
// [RULE_20] Writing a timer restarts it from the beginning of a period.
`timescale 1ns/1ns
`default_nettype none
module cswt_top #(
    parameter int unsigned TICK_CYC = cswt_pkg::TICK_CYC
) (
    // Clock, enable and reset
    input  wire logic                                  clk_sys,
    input  wire logic                                  ce,
    input  wire logic                                  rst_b,
    // APB slave
    input  wire cswt_pkg::cswt_apb_req_t               apb_req,
    output logic [31:0]                                prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    // Device state
    input  wire logic [1:0]                            dev_mode,
    input  wire logic                                  sleep_req,
    input  wire logic [cswt_pkg::N_HS-1:0]             hs_fault,
    // Pins
    input  wire logic [cswt_pkg::N_WK-1:0]             wake_input_pin,
    output logic [cswt_pkg::N_HS-1:0]                  high_side_switch,
    // Wake outputs
    output logic                                       int_b,
    output logic                                       supply_wake,
    output logic                                       restart_req
);

    localparam int unsigned TW = $clog2(TICK_CYC + 1);
    localparam int unsigned NT = cswt_pkg::N_TMR;
    localparam int unsigned NW = cswt_pkg::N_WK;
    localparam int unsigned NH = cswt_pkg::N_HS;
    localparam int unsigned CW = cswt_pkg::CNT_W;
    localparam int unsigned FW = cswt_pkg::FILT_W;

    logic [7:0]    tmr_cfg_r [NT];
    logic [7:0]    map1_r;
    logic [7:0]    map2_r;
    logic [7:0]    wsrc_r;
    logic [NW-1:0] wst1_r;
    logic [NT-1:0] wst2_r;
    logic [NW-1:0] wlvl_r;
    logic          fault_r;
    logic          err_r;
    logic [TW-1:0] tick_cnt_r;
    logic          tick;
    logic [NT-1:0] tmr_wr;
    logic [NT-1:0] tmr_out;
    logic [NT-1:0] on_start;
    logic [NT-1:0] on_end;
    logic [NW-1:0] wk_evt;
    logic [NW-1:0] smp_vld;
    logic [NW-1:0] smp_lvl;
    logic [NW-1:0] wk_sync;
    logic [NW-1:0] cyc_en;
    logic [2*NH-1:0] sw_map;
    logic          acc;
    logic          wr;
    logic          low_pwr_off;
    logic          awake_mode;
    logic          fsafe;
    logic [31:0]   rd_val;
    logic          rd_err;

    assign acc = apb_req.psel && apb_req.penable;
    assign pready = acc && ce;
    assign pslverr = pready && err_r;
    assign wr = pready && apb_req.pwrite && !err_r;
    assign fsafe = (dev_mode == cswt_pkg::MODE_FSAFE);
    assign awake_mode = (dev_mode == cswt_pkg::MODE_NORMAL) ||
                        (dev_mode == cswt_pkg::MODE_STOP);
    assign low_pwr_off = !awake_mode;
    assign sw_map = {map2_r[3:0], map1_r[3:0]};
    assign tmr_wr[0] = wr && (apb_req.paddr == cswt_pkg::ADDR_TMR1);
    assign tmr_wr[1] = wr && (apb_req.paddr == cswt_pkg::ADDR_TMR2);

    // Read mux; the answer is captured in the setup cycle.
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (apb_req.paddr)
            cswt_pkg::ADDR_TMR1:  rd_val[7:0] = tmr_cfg_r[0];
            cswt_pkg::ADDR_TMR2:  rd_val[7:0] = tmr_cfg_r[1];
            cswt_pkg::ADDR_MAP1:  rd_val[7:0] = map1_r;
            cswt_pkg::ADDR_MAP2:  rd_val[7:0] = map2_r;
            cswt_pkg::ADDR_WSRC:  rd_val[7:0] = wsrc_r;
            cswt_pkg::ADDR_WST1:  rd_val[NW-1:0] = wst1_r;
            cswt_pkg::ADDR_WST2:  rd_val[NT-1:0] = wst2_r;
            cswt_pkg::ADDR_WLVL:  rd_val[NW-1:0] = wlvl_r;
            cswt_pkg::ADDR_FAULT: rd_val[0] = fault_r;
            default:              rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            err_r  <= 1'b0;
        end else if (ce && apb_req.psel && !apb_req.penable) begin
            prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_val;
            err_r  <= rd_err;
        end
    end

    // Configuration registers.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tmr_cfg_r[0] <= cswt_pkg::REG_RST;
            tmr_cfg_r[1] <= cswt_pkg::REG_RST;
            map1_r       <= cswt_pkg::REG_RST;
            map2_r       <= cswt_pkg::REG_RST;
            wsrc_r       <= cswt_pkg::REG_RST;
        end else if (ce) begin
            if (tmr_wr[0])
                tmr_cfg_r[0] <= apb_req.pwdata[7:0];
            if (tmr_wr[1])
                tmr_cfg_r[1] <= apb_req.pwdata[7:0];
            if (wr && apb_req.paddr == cswt_pkg::ADDR_MAP1)
                map1_r <= apb_req.pwdata[7:0];
            if (wr && apb_req.paddr == cswt_pkg::ADDR_MAP2)
                map2_r <= apb_req.pwdata[7:0];
            if (wr && apb_req.paddr == cswt_pkg::ADDR_WSRC)
                wsrc_r <= apb_req.pwdata[7:0];
        end
    end

    // Shared 0.1 ms prescaler.
    assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));

    // A timer write realigns the prescaler so the first on-time is a full
    // tick; the other timer may see one stretched tick as the price.
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            tick_cnt_r <= '0;
        else if (ce)
            tick_cnt_r <= (tick || (|tmr_wr)) ? '0 : tick_cnt_r + 1'b1;
    end

    genvar t;
    generate
        for (t = 0; t < NT; t++) begin : g_tmr
            logic [CW-1:0] cnt_r;
            logic [CW-1:0] per;
            logic [CW-1:0] on;
            logic [CW-1:0] new_per;
            logic [CW-1:0] new_on;
            logic          run;
            logic          hold_hi;

            assign per = cswt_pkg::cswt_per_ticks(                    // [RULE_18]
                tmr_cfg_r[t][cswt_pkg::PER_LSB +: 3]);
            assign on = cswt_pkg::cswt_on_ticks(                      // [RULE_19]
                tmr_cfg_r[t][cswt_pkg::ON_LSB +: 3]);
            assign new_per = cswt_pkg::cswt_per_ticks(
                apb_req.pwdata[cswt_pkg::PER_LSB +: 3]);
            assign new_on = cswt_pkg::cswt_on_ticks(
                apb_req.pwdata[cswt_pkg::ON_LSB +: 3]);
            // Running needs only a valid on-time and period.
            assign run = (on != '0) && (per != '0);                   // [RULE_02]
            assign hold_hi = (tmr_cfg_r[t][cswt_pkg::ON_LSB +: 3] ==
                              cswt_pkg::ON_OFF_HIGH);
            // Off codes give a steady level so sensing starts without an edge.
            assign tmr_out[t] = run ? (cnt_r < on) : hold_hi;         // [RULE_04]
            // A wrap begins a new on-time; the first follows the write itself.
            assign on_start[t] = tick && run && (cnt_r == per - 1'b1); // [RULE_16]
            assign on_end[t] = tick && run && (cnt_r == on - 1'b1);

            always_ff @(posedge clk_sys) begin
                if (!rst_b)
                    cnt_r <= '0;
                else if (ce) begin
                    if (tmr_wr[t])
                        cnt_r <= '0;                                  // [RULE_20]
                    else if (tick && run)
                        cnt_r <= on_start[t] ? '0 : cnt_r + 1'b1;
                end
            end
        end
    endgenerate

    // Command fault: on-time longer than the period on a timer write.
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            fault_r <= 1'b0;
        else if (ce) begin
            if (|tmr_wr && (g_tmr[0].new_on > g_tmr[0].new_per))
                fault_r <= 1'b1;                                      // [RULE_05]
            else if (wr && apb_req.paddr == cswt_pkg::ADDR_FAULT &&
                     apb_req.pwdata[0])
                fault_r <= 1'b0;
        end
    end

    // Switch drive. A fault only gates the pin; the timer keeps counting.
    genvar h;
    generate
        for (h = 0; h < NH; h++) begin : g_hs
            logic [1:0] sel;
            logic       drv;
            assign sel = sw_map[h*cswt_pkg::MAP_W +: cswt_pkg::MAP_W];
            assign drv = (sel == cswt_pkg::MAP_T1) ? tmr_out[0] :     // [RULE_17]
                         (sel == cswt_pkg::MAP_T2) ? tmr_out[1] : 1'b0;
            always_ff @(posedge clk_sys) begin
                if (!rst_b)
                    high_side_switch[h] <= 1'b0;
                else if (ce)
                    high_side_switch[h] <= drv && !hs_fault[h] &&     // [RULE_11]
                                           !fsafe;                    // [RULE_10]
            end
        end
    endgenerate

    // Wake inputs: synchroniser, sampler and stability filter.
    genvar w;
    generate
        for (w = 0; w < NW; w++) begin : g_wk
            logic          s1_r;
            logic          s2_r;
            logic          busy_r;
            logic          flvl_r;
            logic          ref_r;
            logic          have_ref_r;
            logic [FW-1:0] fcnt_r;
            logic          tsel;
            logic          cyc;
            logic          start;
            logic          done;

            assign tsel = wsrc_r[cswt_pkg::TSEL_LSB + w];
            // Fail-safe drops back to continuous static sensing.
            assign cyc = wsrc_r[cswt_pkg::CSE_LSB + w] && !fsafe;     // [RULE_10]
            assign start = cyc ? on_end[tsel] :
                           (!busy_r && s2_r != ref_r);
            assign done = busy_r && (s2_r == flvl_r) && (fcnt_r == '0);
            assign wk_sync[w] = s2_r;
            assign cyc_en[w] = cyc;
            assign smp_vld[w] = done && cyc;
            assign smp_lvl[w] = flvl_r;
            assign wk_evt[w] = done && have_ref_r &&                  // [RULE_06]
                               (flvl_r != ref_r);                     // [RULE_07]

            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else if (ce) begin
                    s1_r <= wake_input_pin[w];
                    s2_r <= s1_r;
                end
            end

            // The window opens at the end of the on-time; any change aborts.
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    busy_r <= 1'b0;
                    flvl_r <= 1'b0;
                    fcnt_r <= '0;
                end else if (ce) begin
                    if (start) begin
                        busy_r <= 1'b1;                               // [RULE_07]
                        flvl_r <= s2_r;
                        fcnt_r <= FW'(cswt_pkg::FILT_CYC - 1);
                    end else if (busy_r) begin
                        if (s2_r != flvl_r || fcnt_r == '0)
                            busy_r <= 1'b0;
                        else
                            fcnt_r <= fcnt_r - 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    ref_r      <= 1'b0;
                    have_ref_r <= 1'b0;
                end else if (ce) begin
                    if (tmr_wr[tsel] && cyc)
                        have_ref_r <= 1'b0;                           // [RULE_06]
                    else if (done) begin
                        ref_r      <= flvl_r;
                        have_ref_r <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Level status follows only samples while sensing cyclically in normal or stop.
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            wlvl_r <= '0;
        else if (ce) begin
            for (int i = 0; i < NW; i++) begin
                if (!cyc_en[i] || low_pwr_off)
                    wlvl_r[i] <= wk_sync[i];
                else if (smp_vld[i])
                    wlvl_r[i] <= smp_lvl[i];                          // [RULE_09]
            end
        end
    end

    // Wake flags: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wst1_r <= '0;
            wst2_r <= '0;
        end else if (ce) begin
            wst1_r <= (wst1_r & ~((wr && apb_req.paddr ==
                       cswt_pkg::ADDR_WST1) ? apb_req.pwdata[NW-1:0] : '0))
                      | wk_evt;                                       // [RULE_08]
            wst2_r <= (wst2_r & ~((wr && apb_req.paddr ==
                       cswt_pkg::ADDR_WST2) ? apb_req.pwdata[NT-1:0] : '0))
                      | (on_start & wsrc_r[cswt_pkg::TWE_LSB +: NT]);
        end
    end

    // Wake signalling by mode.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            int_b       <= 1'b1;
            supply_wake <= 1'b0;
            restart_req <= 1'b0;
        end else if (ce) begin
            int_b <= !(awake_mode && ((|wk_evt) ||                    // [RULE_01]
                     (|(on_start & wsrc_r[cswt_pkg::TWE_LSB +: NT])))); // [RULE_14]
            supply_wake <= low_pwr_off && (|wk_evt);                  // [RULE_01]
            restart_req <= sleep_req &&
                           ((|wst1_r) || (|wst2_r));                  // [RULE_13]
        end
    end

endmodule
`default_nettype wire

/* tb/cswt_top_properties.sv */
// Purpose: Port checks for the cyclic sense wake timer.
// Assumes: dev_mode is held steady around wake events.
// Notes:   Bound into every cswt_top instance.
`timescale 1ns/1ns
`default_nettype none
module cswt_top_properties #(
    parameter int unsigned TICK_CYC = cswt_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic                      clk_sys,
    input wire logic                      ce,
    input wire logic                      rst_b,
    // APB
    input wire cswt_pkg::cswt_apb_req_t   apb_req,
    input wire logic                      pready,
    // Device state
    input wire logic [1:0]                dev_mode,
    input wire logic                      sleep_req,
    input wire logic [cswt_pkg::N_HS-1:0] hs_fault,
    // Outputs
    input wire logic [cswt_pkg::N_HS-1:0] high_side_switch,
    input wire logic                      int_b,
    input wire logic                      supply_wake,
    input wire logic                      restart_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_fsafe;
        ce && dev_mode == cswt_pkg::MODE_FSAFE |=> high_side_switch == '0;
    endproperty
    a_fsafe: assert property (p_fsafe)
        else $error("switch driven in fail-safe");
    property p_fault;
        ce && |hs_fault |=> (high_side_switch & $past(hs_fault)) == '0;
    endproperty
    a_fault: assert property (p_fault)
        else $error("faulted switch still driven");
    property p_intm;
        $fell(int_b) |-> dev_mode inside {2'h0, 2'h1};
    endproperty
    a_intm: assert property (p_intm)
        else $error("interrupt outside normal or stop");
    property p_supm;
        supply_wake |-> dev_mode inside {2'h2, 2'h3};
    endproperty
    a_supm: assert property (p_supm)
        else $error("supply wake outside sleep or fail-safe");
    property p_intp;
        !int_b |=> int_b;
    endproperty
    a_intp: assert property (p_intp)
        else $error("interrupt pulse too long");
    property p_supp;
        supply_wake |=> !supply_wake;
    endproperty
    a_supp: assert property (p_supp)
        else $error("supply wake pulse too long");
    property p_rst;
        restart_req |-> $past(sleep_req);
    endproperty
    a_rst: assert property (p_rst)
        else $error("restart without sleep request");
    property p_slp;
        (dev_mode == cswt_pkg::MODE_SLEEP)[*4] |-> int_b;
    endproperty
    a_slp: assert property (p_slp)
        else $error("interrupt in sleep");
    property p_rdy;
        apb_req.psel && apb_req.penable && ce |-> pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("access phase without ready");
endmodule

bind cswt_top cswt_top_properties #(.TICK_CYC(TICK_CYC)) u_props (
    .clk_sys(clk_sys), .ce(ce), .rst_b(rst_b), .apb_req(apb_req),
    .pready(pready), .dev_mode(dev_mode), .sleep_req(sleep_req),
    .hs_fault(hs_fault), .high_side_switch(high_side_switch),
    .int_b(int_b), .supply_wake(supply_wake), .restart_req(restart_req)
);
`default_nettype wire

/* tb/cswt_wake_net.sv */
// Purpose: Contacts on the wake inputs, fed by the high-side switches.
// Assumes: Input i is supplied by switch i, with a pull-down to ground.
// Notes:   The input RC holds the level HOLD_CYC clocks after the switch
//          opens; it must outlast the wake filter or no sample is clean.
`timescale 1ns/1ns
`default_nettype none
module cswt_wake_net #(
    parameter int HOLD_CYC = 2100
) (
    // Clock
    input  wire logic                      clk_sys,
    // Switch drive and contact state
    input  wire logic [cswt_pkg::N_HS-1:0] high_side_switch,
    input  wire logic [cswt_pkg::N_WK-1:0] closed,
    // Wake inputs
    output var  logic [cswt_pkg::N_WK-1:0] wake_input_pin
);
    int hold_r [cswt_pkg::N_WK] = '{default: 0};

    initial wake_input_pin = '0;
    always @(posedge clk_sys) begin
        for (int i = 0; i < cswt_pkg::N_WK; i++) begin
            if (high_side_switch[i]) begin
                wake_input_pin[i] <= closed[i];
                hold_r[i]         <= HOLD_CYC;
            end else if (hold_r[i] > 0) begin
                hold_r[i] <= hold_r[i] - 1;
            end else begin
                // Unsupplied input falls to its pull-down.
                wake_input_pin[i] <= 1'h0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the cyclic sense wake timer.
// Assumes: One tick is 20 clocks here; the wake filter stays 2000 clocks.
// Notes:   Waits follow programmed periods with margin for the prescaler.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int PER_T [7] = '{100, 200, 500, 1000, 2000, 10000, 20000};
    localparam int ON_T [6]  = '{0, 1, 3, 10, 100, 200};
    logic                      clk_sys   = 1'h0;
    logic                      rst_b     = 1'h0;
    cswt_pkg::cswt_apb_req_t   req       = '0;
    logic [1:0]                dev_mode  = 2'h0;
    logic                      sleep_req = 1'h0;
    logic [cswt_pkg::N_HS-1:0] hs_fault  = '0;
    logic [cswt_pkg::N_WK-1:0] closed    = '0;
    logic [cswt_pkg::N_WK-1:0] wk_pin;
    logic [cswt_pkg::N_HS-1:0] hs;
    logic [31:0]               prdata;
    logic [31:0]               rd;
    logic                      pready;
    logic                      pslverr;
    logic                      err;
    logic                      int_b;
    logic                      supply_wake;
    logic                      restart_req;
    int                        error_cnt = 0;
    int                        checks    = 0;
    int                        n_int     = 0;
    int                        n_sup     = 0;

    cswt_top #(.TICK_CYC(20)) dut (
        .clk_sys(clk_sys), .ce(1'h1), .rst_b(rst_b), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dev_mode(dev_mode), .sleep_req(sleep_req), .hs_fault(hs_fault),
        .wake_input_pin(wk_pin), .high_side_switch(hs), .int_b(int_b),
        .supply_wake(supply_wake), .restart_req(restart_req)
    );
    cswt_wake_net net (
        .clk_sys(clk_sys), .high_side_switch(hs), .closed(closed),
        .wake_input_pin(wk_pin)
    );

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (int_b === 1'h0) n_int++;
        if (supply_wake === 1'h1) n_sup++;
    end

    task automatic print_verdict();
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'h1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        req <= '0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, string s);
        apb(1'h0, a, 32'h0);
        chk(rd, e, s);
    endtask
    task automatic sleep_try(input logic [31:0] exp);
        sleep_req <= 1'h1;
        @(posedge clk_sys);
        sleep_req <= 1'h0;
        @(negedge clk_sys);
        chk(32'(restart_req), exp, "restart request");
        @(posedge clk_sys);
    endtask

    initial begin
        logic [31:0] f;
        cyc(8);
        rst_b <= 1'h1;
        cyc(1);
        for (int a = 0; a <= 'h20; a += 4) rdc(8'(a), 32'h0, "reset value");
        apb(1'h0, 8'h24, 32'h0);
        chk(32'(err), 32'h1, "unmapped error");
        for (int p = 0; p < 7; p++) begin
            for (int o = 1; o < 6; o++) begin
                f = 32'(ON_T[o] > PER_T[p]);
                wr(cswt_pkg::ADDR_TMR1, 32'(o * 16 + p));
                rdc(cswt_pkg::ADDR_FAULT, f, "fault");
                wr(cswt_pkg::ADDR_FAULT, 32'h1);
            end
        end
        wr(cswt_pkg::ADDR_TMR1, 32'h7);
        wr(cswt_pkg::ADDR_MAP2, 32'h8);
        wr(cswt_pkg::ADDR_TMR2, 32'h60);
        cyc(4);
        chk(32'(hs), 32'h8, "off high");
        hs_fault <= 4'h8;
        cyc(3);
        chk(32'(hs), 32'h0, "faulted switch");
        hs_fault <= 4'h0;
        dev_mode <= cswt_pkg::MODE_FSAFE;
        cyc(3);
        chk(32'(hs), 32'h0, "fail-safe switch");
        dev_mode <= cswt_pkg::MODE_NORMAL;
        wr(cswt_pkg::ADDR_TMR2, 32'h0);
        cyc(3);
        chk(32'(hs), 32'h0, "off low");
        wr(cswt_pkg::ADDR_TMR2, 32'h7);
        wr(cswt_pkg::ADDR_WSRC, 32'h1);
        // Switches faulted: the timer must keep interrupting regardless.
        hs_fault <= 4'hF;
        n_int = 0;
        wr(cswt_pkg::ADDR_TMR1, 32'h10);
        cyc(1900);
        chk(32'(n_int), 32'h0, "first on-time");
        cyc(5000);
        chk(32'(n_int), 32'h3, "cyclic wake");
        rdc(cswt_pkg::ADDR_WST2, 32'h1, "timer flag");
        wr(cswt_pkg::ADDR_TMR1, 32'h7);
        wr(cswt_pkg::ADDR_WST2, 32'h3);
        hs_fault <= 4'h0;
        wr(cswt_pkg::ADDR_TMR1, 32'h1);
        wr(cswt_pkg::ADDR_MAP1, 32'h1);
        wr(cswt_pkg::ADDR_WSRC, 32'h4);
        closed <= 3'h1;
        n_int = 0;
        wr(cswt_pkg::ADDR_TMR1, 32'h11);
        cyc(3000);
        rdc(cswt_pkg::ADDR_WLVL, 32'h1, "sampled level");
        rdc(cswt_pkg::ADDR_WST1, 32'h0, "reference");
        closed <= 3'h0;
        cyc(4000);
        rdc(cswt_pkg::ADDR_WST1, 32'h1, "wake flag");
        rdc(cswt_pkg::ADDR_WLVL, 32'h0, "new level");
        chk(32'(n_int), 32'h1, "sense interrupt");
        sleep_try(32'h1);
        wr(cswt_pkg::ADDR_WST1, 32'h7);
        wr(cswt_pkg::ADDR_WST2, 32'h3);
        sleep_try(32'h0);
        dev_mode <= cswt_pkg::MODE_SLEEP;
        closed <= 3'h1;
        n_sup = 0;
        cyc(4000);
        chk(32'(n_sup), 32'h1, "supply wake");
        chk(32'(n_int), 32'h1, "sleep interrupt");
        rdc(cswt_pkg::ADDR_WST1, 32'h1, "sleep flag");
        print_verdict();
    end

    initial begin
        cyc(40000);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
